// >>> core/dcc_defs.svh
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

`define DCC_NUM_CMP        2
`define DCC_CTRL_W         8
`define DCC_MODE_W         2
`define DCC_HYP_LSB        2
`define DCC_HYN_LSB        0
`define DCC_HY_W           2
`define DCC_EN_BIT         7
`define DCC_OUT_BIT        6
`define DCC_RIF_BIT        5
`define DCC_FIF_BIT        4
`define DCC_CTRL_RST       8'h00
`define DCC_MODE_RST       2'h2
`define DCC_HY_RST         2'h0
`define DCC_SYNC_STAGES    3

`endif

// >>> core/dcc_pkg.sv
`include "dcc_defs.svh"

package dcc_pkg;
  typedef logic [`DCC_CTRL_W-1:0] dcc_ctrl_t;
  typedef logic [`DCC_MODE_W-1:0] dcc_mode_t;
  typedef logic [`DCC_HY_W-1:0]   dcc_hyst_t;
  typedef logic [`DCC_NUM_CMP-1:0] dcc_vec_t;
  // hysteresis codes: 0 disabled, 1 5 mV, 2 10 mV, 3 20 mV
  typedef enum logic [1:0] {
    DCC_HY_OFF  = 2'h0,
    DCC_HY_5MV  = 2'h1,
    DCC_HY_10MV = 2'h2,
    DCC_HY_20MV = 2'h3
  } dcc_hy_t;
endpackage : dcc_pkg

// >>> core/dcc_edge_if.sv
`timescale 1ns/1ns

interface dcc_edge_if;
  logic raw;
  logic level;
  logic rise;
  logic fall;
  modport det (input raw, output level, output rise, output fall);
  modport use_side (output raw, input level, input rise, input fall);
endinterface : dcc_edge_if

// >>> core/dcc_edge_det.sv
`timescale 1ns/1ns
`include "dcc_defs.svh"

module dcc_edge_det (
  input  wire logic  ref_clk,
  input  wire logic  rstn,
  dcc_edge_if.det    e
);
  import dcc_pkg::*;

  logic [`DCC_SYNC_STAGES-1:0] sync;
  logic                        level;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync <= '0;
    end else begin
      sync <= {sync[`DCC_SYNC_STAGES-2:0], e.raw};
    end
  end

  // change accepted once stages two and three agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      level <= 1'b0;
    end else if (sync[1] == sync[2]) begin
      level <= sync[2];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      e.rise <= 1'b0;
      e.fall <= 1'b0;
    end else begin
      e.rise <= (sync[1] == sync[2]) && sync[2] && !level;
      e.fall <= (sync[1] == sync[2]) && !sync[2] && level;
    end
  end

  assign e.level = level;
endmodule : dcc_edge_det

// >>> core/dcc_top.sv
// Functional notes
// - two independent comparators, each with its own control register
// - output readable, usable as interrupt source, and routable to a pin
// - pin output selectable synchronous or asynchronous; async needs no clock
// - disabled comparator drives its pin output low
// - writable response time per comparator; longer means lower current
// - hysteresis fields sit in control bits 3 down to 0
// - negative hysteresis: 20, 10, 5 mV or off
// - positive hysteresis coded likewise, independent of negative
// - interrupt request on rising and on falling edges
// - falling edge sets the falling flag
// - rising edge sets the rising flag independently
// - flags stay set until software writes zero
// - read-only state bit shows present output level
// - enable bit: one turns on, zero turns off
// - spurious edges possible after enable or mode change
`timescale 1ns/1ns
`include "dcc_defs.svh"

module dcc_top (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire dcc_pkg::dcc_vec_t cmp_raw,
  input  wire dcc_pkg::dcc_vec_t ctrl_wr,
  input  wire dcc_pkg::dcc_ctrl_t ctrl_wdata,
  input  wire dcc_pkg::dcc_vec_t mode_wr,
  input  wire dcc_pkg::dcc_mode_t mode_wdata,
  input  wire dcc_pkg::dcc_vec_t pin_async_sel,
  output logic [2*`DCC_CTRL_W-1:0] ctrl_rdata,
  output logic [2*`DCC_MODE_W-1:0] mode_rdata,
  output dcc_pkg::dcc_vec_t      analog_enable,
  output logic [2*`DCC_HY_W-1:0] hyn_sel,
  output logic [2*`DCC_HY_W-1:0] hyp_sel,
  output logic [2*`DCC_MODE_W-1:0] response_sel,
  output dcc_pkg::dcc_vec_t      rise_irq,
  output dcc_pkg::dcc_vec_t      fall_irq,
  output dcc_pkg::dcc_vec_t      cmp_pin
);
  import dcc_pkg::*;

  dcc_vec_t  enable;
  dcc_vec_t  rise_flag;
  dcc_vec_t  fall_flag;
  dcc_vec_t  sync_pin;
  dcc_vec_t  level;
  dcc_vec_t  rise_p;
  dcc_vec_t  fall_p;
  dcc_hyst_t hyn    [`DCC_NUM_CMP];
  dcc_hyst_t hyp    [`DCC_NUM_CMP];
  dcc_mode_t mode   [`DCC_NUM_CMP];

  genvar n;
  generate
    for (n = 0; n < `DCC_NUM_CMP; n++) begin : g_cmp
      dcc_edge_if eif ();
      assign eif.raw = cmp_raw[n];

      dcc_edge_det u_det (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .e       (eif)
      );
      assign level[n]  = eif.level;
      assign rise_p[n] = eif.rise & enable[n];
      assign fall_p[n] = eif.fall & enable[n];

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          enable[n] <= 1'b0;
        end else if (ctrl_wr[n]) begin
          enable[n] <= ctrl_wdata[`DCC_EN_BIT];
        end
      end

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          hyn[n] <= `DCC_HY_RST;
          hyp[n] <= `DCC_HY_RST;
        end else if (ctrl_wr[n]) begin
          hyn[n] <= ctrl_wdata[`DCC_HYN_LSB +: `DCC_HY_W];
          hyp[n] <= ctrl_wdata[`DCC_HYP_LSB +: `DCC_HY_W];
        end
      end

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          mode[n] <= `DCC_MODE_RST;
        end else if (mode_wr[n]) begin
          mode[n] <= mode_wdata;
        end
      end

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          fall_flag[n] <= 1'b0;
        end else if (fall_p[n]) begin
          fall_flag[n] <= 1'b1;
        end else if (ctrl_wr[n] && !ctrl_wdata[`DCC_FIF_BIT]) begin
          fall_flag[n] <= 1'b0;
        end
      end

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          rise_flag[n] <= 1'b0;
        end else if (rise_p[n]) begin
          rise_flag[n] <= 1'b1;
        end else if (ctrl_wr[n] && !ctrl_wdata[`DCC_RIF_BIT]) begin
          rise_flag[n] <= 1'b0;
        end
      end

      // registered pin copy for the synchronous route
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          sync_pin[n] <= 1'b0;
        end else begin
          sync_pin[n] <= level[n] & enable[n];
        end
      end

      // async path bypasses clock, valid when stopped
      assign cmp_pin[n] = pin_async_sel[n] ? (cmp_raw[n] & enable[n]) : sync_pin[n];

      assign ctrl_rdata[n*`DCC_CTRL_W +: `DCC_CTRL_W] =
        {enable[n], level[n] & enable[n], rise_flag[n], fall_flag[n], hyp[n], hyn[n]};
      assign mode_rdata[n*`DCC_MODE_W +: `DCC_MODE_W]     = mode[n];
      assign hyn_sel[n*`DCC_HY_W +: `DCC_HY_W]            = hyn[n];
      assign hyp_sel[n*`DCC_HY_W +: `DCC_HY_W]            = hyp[n];
      assign response_sel[n*`DCC_MODE_W +: `DCC_MODE_W]   = mode[n];
    end
  endgenerate

  assign rise_irq = rise_flag;
  assign fall_irq = fall_flag;

  assign analog_enable = enable;
endmodule : dcc_top

// >>> verification/dcc_top_properties.sv
`timescale 1ns/1ns
module dcc_chk (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [1:0]  cmp_raw,
  input wire logic [1:0]  ctrl_wr,
  input wire logic [7:0]  ctrl_wdata,
  input wire logic [1:0]  pin_async_sel,
  input wire logic [1:0]  mode_wr,
  input wire logic [1:0]  mode_wdata,
  input wire logic [15:0] ctrl_rdata,
  input wire logic [3:0]  mode_rdata,
  input wire logic [1:0]  analog_enable,
  input wire logic [3:0]  hyn_sel,
  input wire logic [3:0]  hyp_sel,
  input wire logic [3:0]  response_sel,
  input wire logic [1:0]  rise_irq,
  input wire logic [1:0]  fall_irq,
  input wire logic [1:0]  cmp_pin
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_en; ctrl_wr[0] |=> analog_enable[0] == $past(ctrl_wdata[7]); endproperty
  a_en: assert property (p_en) else $error("enable not taken");
  property p_hy; ctrl_wr[0] |=> ctrl_rdata[3:0] == $past(ctrl_wdata[3:0]); endproperty
  a_hy: assert property (p_hy) else $error("hysteresis not taken");
  property p_keep; rise_irq[0] && !ctrl_wr[0] |=> rise_irq[0]; endproperty
  a_keep: assert property (p_keep) else $error("flag dropped");
  property p_rise; $rose(cmp_raw[0]) && analog_enable[0] ##1
    (cmp_raw[0] && analog_enable[0] && !ctrl_wr[0]) [*6] |-> rise_irq[0]; endproperty
  a_rise: assert property (p_rise) else $error("rise flag late");
  property p_fall; $fell(cmp_raw[0]) && analog_enable[0] ##1
    (!cmp_raw[0] && analog_enable[0] && !ctrl_wr[0]) [*6] |-> ctrl_rdata[4]; endproperty
  a_fall: assert property (p_fall) else $error("fall flag late");
  property p_out; (cmp_raw[0] && analog_enable[0]) [*7] |-> ctrl_rdata[6]; endproperty
  a_out: assert property (p_out) else $error("state bit stale");
  property p_async; pin_async_sel[0] |-> cmp_pin[0] == (cmp_raw[0] & analog_enable[0]);
  endproperty
  a_async: assert property (p_async) else $error("async pin wrong");
  property p_off; !analog_enable[0] [*5] |-> !cmp_pin[0]; endproperty
  a_off: assert property (p_off) else $error("pin high while off");
  property p_hsel; ctrl_wr[1] |=> hyn_sel[3:2] == $past(ctrl_wdata[1:0]) &&
    hyp_sel[3:2] == $past(ctrl_wdata[3:2]); endproperty
  a_hsel: assert property (p_hsel) else $error("hysteresis select not taken");
  property p_resp; mode_wr[0] |=> response_sel[1:0] == $past(mode_wdata) &&
    mode_rdata[1:0] == $past(mode_wdata); endproperty
  a_resp: assert property (p_resp) else $error("response time not taken");
  property p_fkeep; fall_irq[1] && !ctrl_wr[1] |=> fall_irq[1]; endproperty
  a_fkeep: assert property (p_fkeep) else $error("falling flag dropped");
  c_rise: cover property (rise_irq[0]);
  c_off: cover property (!analog_enable[0] && cmp_raw[0]);
  c_async: cover property (pin_async_sel[0] && cmp_pin[0]);
endmodule : dcc_chk
bind dcc_top dcc_chk i_chk (.ref_clk, .rstn, .cmp_raw, .ctrl_wr, .ctrl_wdata,
  .pin_async_sel, .mode_wr, .mode_wdata, .ctrl_rdata, .mode_rdata, .analog_enable,
  .hyn_sel, .hyp_sel, .response_sel, .rise_irq, .fall_irq, .cmp_pin);

// >>> verification/dcc_cmp_model.sv
`timescale 1ns/1ns
module dcc_cmp_model (
  input  wire logic [1:0] vin_above,
  output wire logic [1:0] cmp_raw
);
  // analog delay keeps edges clear of the clock
  assign #3 cmp_raw = vin_above;
endmodule : dcc_cmp_model

// >>> verification/dcc_top_tb.sv
`timescale 1ns/1ns
module dcc_top_tb;
  import dcc_pkg::*;
  logic        ref_clk = 0;
  logic        rstn = 0;
  dcc_vec_t    vin = 0, ctrl_wr = 0, mode_wr = 0, pin_async_sel = 0;
  dcc_vec_t    cmp_raw, analog_enable, rise_irq, fall_irq, cmp_pin;
  dcc_ctrl_t   ctrl_wdata = 0;
  dcc_mode_t   mode_wdata = 0;
  logic [15:0] ctrl_rdata;
  logic [3:0]  mode_rdata, hyn_sel, hyp_sel, response_sel;
  logic [9:0]  q[$], e;
  logic [31:0] vw;
  string       nm[4] = '{"ctrl0", "ctrl1", "mode", "pin"};
  int          err_total = 0, checked = 0, seed = 2319, k;
  always #5 ref_clk = ~ref_clk;
  dcc_cmp_model i_mdl (.vin_above(vin), .cmp_raw);
  dcc_top i_dut (.ref_clk, .rstn, .cmp_raw, .ctrl_wr, .ctrl_wdata, .mode_wr, .mode_wdata,
    .pin_async_sel, .ctrl_rdata, .mode_rdata, .analog_enable, .hyn_sel, .hyp_sel,
    .response_sel, .rise_irq, .fall_irq, .cmp_pin);
  assign vw = {6'h00, cmp_pin, 4'h0, mode_rdata, ctrl_rdata};
  task cmp(input string n, input logic [7:0] x, input logic [7:0] s);
    checked++;
    if (s !== x) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask : cmp
  task wr(input logic md, input int n, input logic [7:0] d);
    @(negedge ref_clk);
    if (md) mode_wr[n] = 1;
    else ctrl_wr[n] = 1;
    ctrl_wdata = d;
    mode_wdata = d[1:0];
    @(negedge ref_clk);
    ctrl_wr = 0;
    mode_wr = 0;
  endtask : wr
  task note(input logic [1:0] kd, input logic [7:0] v);
    @(negedge ref_clk);
    q.push_back({kd, v});
  endtask : note
  task report_and_stop;
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // compare just after the falling edge, once that edge's note is queued
  always @(negedge ref_clk) begin
    #1;
    if (q.size() > 0) begin
      e = q.pop_front();
      cmp(nm[e[9:8]], e[7:0], vw[8*e[9:8] +: 8]);
    end
  end
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(negedge ref_clk);
    rstn = 1;
    note(0, 8'h00);
    note(2, 8'h0A);
    for (k = 0; k < 4; k++) begin
      wr(0, 0, 8'(8'h80 | (3 - k) << 2 | k));
      note(0, 8'(8'h80 | (3 - k) << 2 | k));
      wr(1, 0, 8'(k));
      note(2, 8'(8 | k));
    end
    wr(0, 1, 8'h8E);
    note(1, 8'h8E);
    vin[0] = 1;
    repeat (8) @(negedge ref_clk);
    note(0, 8'hE3);
    note(1, 8'h8E);
    note(3, 8'h01);
    wr(0, 0, 8'hB3);
    note(0, 8'hE3);
    vin[0] = 0;
    repeat (8) @(negedge ref_clk);
    note(0, 8'hB3);
    wr(0, 0, 8'h83);
    note(0, 8'h83);
    pin_async_sel[0] = 1;
    vin[0] = 1;
    repeat (8) @(negedge ref_clk);
    note(3, 8'h01);
    wr(0, 0, 8'h30);
    note(3, 8'h00);
    note(0, 8'h20);
    for (k = 0; k < 6; k++) begin
      pin_async_sel[1] = 1'($random(seed));
      vin[1] = ~vin[1];
      repeat (8 + ($random(seed) & 3)) @(negedge ref_clk);
      note(3, {6'h00, vin[1], 1'b0});
    end
    note(1, 8'hBE);
    repeat (3) @(negedge ref_clk);
    report_and_stop();
  end
endmodule : dcc_top_tb
